// [verilog/port_cfg.svh]
// register offsets, reset values and field positions for the six-bit port
// assumes an APB slave with 32-bit data, one register per aligned word
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

`define OFS_PIN_VALUE    12'h000
`define OFS_DIRECTION    12'h004
`define OFS_ANALOG_LOW   12'h008
`define OFS_ANALOG_HIGH  12'h00C
`define OFS_PULLUP       12'h010
`define OFS_CHANGE_EN    12'h014
`define OFS_CONTROL      12'h018
`define OFS_STATUS       12'h01C

`define RST_DIRECTION    6'h3F
`define RST_ANALOG_LOW   8'hFF
`define RST_ANALOG_HIGH  4'hF
`define RST_PULLUP       6'h37
`define RST_CHANGE_EN    6'h00
`define RST_CONTROL      8'h01

`define PIN_INPUT_ONLY   3
`define MASK_NO_PIN3     6'h37
`define MASK_XTAL_PINS   6'h30

`define CTL_GPU          0
`define CTL_WAKE         1
`define CTL_GIE          2
`define CTL_SLEEP        3
`define CTL_MASTER_CLEAR_PIN         4
`define CTL_OSC_LSB      5

`define ST_FLAG          0
`define ST_WAKE          1
`define ST_VECTOR        2

`define VECTOR_ADDR      13'h0004

`endif

// [verilog/port_pkg.sv]
// types shared by the six-bit port
// assumes port_cfg.svh holds all offsets and constants
package port_pkg;
  typedef enum logic [2:0] {
    osc_internal   = 3'b000,
    osc_crystal_lp = 3'b001,
    osc_crystal_xt = 3'b010,
    osc_crystal_hs = 3'b011,
    osc_external   = 3'b100
  } osc_mode_e;

  typedef enum logic [1:0] {
    run_awake   = 2'b00,
    run_asleep  = 2'b01,
    run_waking  = 2'b10
  } run_state_e;
endpackage

// [verilog/six_bit_port.sv]
// six-bit general purpose port with change detect and slow-discharge wake
// assumes an APB master on pclk, pin levels already synchronous to pclk
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "port_cfg.svh"

// Summary of operation
// - direction one tri-states, zero drives latch
// - direction bit three always reads one
// - crystal modes: direction bits five, four read one
// - value bits seven, six read zero
// - analog pins read zero; writes take pwdata as given
// - analog select never blocks output drive
// - analog disables input, pull-up, change detect
// - high analog select: four bits, reset ones
// - per-pin pull-up enable, bit three absent
// - pull-up off while pin is output
// - global pull-up gate, disabled at power-on
// - pin three pull-up follows master clear
// - crystal modes: pull-up bits five, four read one
// - per-pin change enable, cleared at power-on
// - mismatch against last read sets flag
// - mismatch keeps flag set; port access ends it
// - last-read latch survives soft resets
// - change during read still sets flag
// - change flag wakes device from sleep
// - global enable gates interrupt, vector 0004h
// - low-power wake enables sink on pin zero
// - crystal modes: change bits five, four read one
// - read returns pins, write loads the latch from pwdata
// - pin three reads zero as master clear
module six_bit_port
  import port_pkg::*;
#(
  parameter int NPINS = 6
)(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // soft reset (master clear or brown-out), keeps the last-read latch
  input  wire logic        soft_rst_n,
  // pins
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe,
  output logic      [5:0]  pullup_on,
  output logic             wake_sink_on,
  // core side
  output logic             change_interrupt_flag,
  output logic             wake_request,
  output logic             irq_vector_valid,
  output logic      [12:0] irq_vector
);

  logic [5:0]  latch_reg,   latch_next;
  logic [5:0]  dir_reg,     dir_next;
  logic [7:0]  ans_lo_reg,  ans_lo_next;
  logic [3:0]  ans_hi_reg,  ans_hi_next;
  logic [5:0]  wpu_reg,     wpu_next;
  logic [5:0]  ioc_reg,     ioc_next;
  logic [7:0]  ctl_reg,     ctl_next;
  logic [5:0]  last_reg,    last_next;
  logic        flag_reg,    flag_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic        ready_reg,   ready_next;
  logic        err_reg,     err_next;
  logic [5:0]  pout_reg,    pout_next;
  logic [5:0]  poe_reg,     poe_next;
  logic [5:0]  pull_reg,    pull_next;
  logic        sink_reg,    sink_next;
  logic        wake_reg,    wake_next;
  logic        vec_reg,     vec_next;
  run_state_e  run_reg,     run_next;

  osc_mode_e   osc_mode;
  logic        xtal;
  logic        master_clear_pin_sel;
  logic [5:0]  ans_pin;
  logic [5:0]  dig_in;
  logic [5:0]  dir_rd;
  logic [5:0]  wpu_rd;
  logic [5:0]  ioc_rd;
  logic [5:0]  mismatch;
  logic        setup_ph;
  logic        port_touch;
  logic        flag_clr;

  assign osc_mode = osc_mode_e'(ctl_reg[`CTL_OSC_LSB +: 3]);
  assign xtal     = (osc_mode == osc_crystal_lp) || (osc_mode == osc_crystal_xt)
                 || (osc_mode == osc_crystal_hs);
  assign master_clear_pin_sel = ctl_reg[`CTL_MASTER_CLEAR_PIN];
  // pin to channel map: pins 0..2 on channels 0..2, pin 4 on channel 3
  assign ans_pin  = {1'b0, ans_lo_reg[3], 1'b0, ans_lo_reg[2:0]};

  // digital input buffer per pin
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      assign dig_in[g] = ans_pin[g] ? 1'b0 : pin_in[g];
      assign mismatch[g] = ioc_rd[g] & ~ans_pin[g] & (dig_in[g] ^ last_reg[g]);
    end
  endgenerate

  // read views with forced bits
  always_comb
  begin
    dir_rd = dir_reg;
    dir_rd[`PIN_INPUT_ONLY] = 1'b1;
    wpu_rd = wpu_reg & `MASK_NO_PIN3;
    ioc_rd = ioc_reg;
    if (xtal)
    begin
      dir_rd = dir_rd | `MASK_XTAL_PINS;
      wpu_rd = wpu_rd | `MASK_XTAL_PINS;
      ioc_rd = ioc_rd | `MASK_XTAL_PINS;
    end
  end

  assign setup_ph   = psel & ~penable;
  assign port_touch = psel & penable & ready_reg & (paddr == `OFS_PIN_VALUE);
  assign flag_clr   = psel & penable & ready_reg & pwrite & (paddr == `OFS_STATUS)
                    & pwdata[`ST_FLAG];

  // apb register file
  always_comb
  begin
    dir_next    = dir_reg;
    ans_lo_next = ans_lo_reg;
    ans_hi_next = ans_hi_reg;
    wpu_next    = wpu_reg;
    ioc_next    = ioc_reg;
    ctl_next    = ctl_reg;
    latch_next  = latch_reg;
    rdata_next  = rdata_reg;
    ready_next  = 1'b0;
    err_next    = 1'b0;
    if (setup_ph)
    begin
      ready_next = 1'b1;
      rdata_next = '0;
      case (paddr)
        `OFS_PIN_VALUE:
        begin
          rdata_next[5:0] = dig_in;
          if (master_clear_pin_sel)
            rdata_next[`PIN_INPUT_ONLY] = 1'b0;
        end
        `OFS_DIRECTION:   rdata_next[5:0] = dir_rd;
        `OFS_ANALOG_LOW:  rdata_next[7:0] = ans_lo_reg;
        `OFS_ANALOG_HIGH: rdata_next[3:0] = ans_hi_reg;
        `OFS_PULLUP:      rdata_next[5:0] = wpu_rd;
        `OFS_CHANGE_EN:   rdata_next[5:0] = ioc_rd;
        `OFS_CONTROL:     rdata_next[7:0] = ctl_reg;
        `OFS_STATUS:
        begin
          rdata_next[`ST_FLAG]   = flag_reg;
          rdata_next[`ST_WAKE]   = wake_reg;
          rdata_next[`ST_VECTOR] = vec_reg;
        end
        default: err_next = 1'b1;
      endcase
    end
    if (psel & penable & ready_reg & pwrite & ~err_reg)
    begin
      case (paddr)
        // all six latch bits come from pwdata; nothing is read back from the pins
        `OFS_PIN_VALUE:   latch_next = pwdata[5:0];
        `OFS_DIRECTION:   dir_next   = pwdata[5:0];
        `OFS_ANALOG_LOW:  ans_lo_next = pwdata[7:0];
        `OFS_ANALOG_HIGH: ans_hi_next = pwdata[3:0];
        `OFS_PULLUP:      wpu_next   = pwdata[5:0] & `MASK_NO_PIN3;
        `OFS_CHANGE_EN:   ioc_next   = pwdata[5:0];
        `OFS_CONTROL:     ctl_next   = pwdata[7:0];
        default:          ctl_next   = ctl_reg;
      endcase
    end
  end

  // config registers, power-on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_reg    <= `RST_DIRECTION;
      ans_lo_reg <= `RST_ANALOG_LOW;
      ans_hi_reg <= `RST_ANALOG_HIGH;
      wpu_reg    <= `RST_PULLUP;
      ioc_reg    <= `RST_CHANGE_EN;
      ctl_reg    <= `RST_CONTROL;
      latch_reg  <= 6'h00;
      rdata_reg  <= 32'h0000_0000;
      ready_reg  <= 1'b0;
      err_reg    <= 1'b0;
    end
    else if (!soft_rst_n)
    begin
      dir_reg    <= `RST_DIRECTION;
      ans_lo_reg <= `RST_ANALOG_LOW;
      ans_hi_reg <= `RST_ANALOG_HIGH;
      wpu_reg    <= `RST_PULLUP;
      ioc_reg    <= `RST_CHANGE_EN;
      ctl_reg    <= `RST_CONTROL;
      ready_reg  <= 1'b0;
      err_reg    <= 1'b0;
    end
    else
    begin
      dir_reg    <= dir_next;
      ans_lo_reg <= ans_lo_next;
      ans_hi_reg <= ans_hi_next;
      wpu_reg    <= wpu_next;
      ioc_reg    <= ioc_next;
      ctl_reg    <= ctl_next;
      latch_reg  <= latch_next;
      rdata_reg  <= rdata_next;
      ready_reg  <= ready_next;
      err_reg    <= err_next;
    end
  end

  // change detect; a pin edge in the access cycle is loaded into the latch and still sets the flag
  always_comb
  begin
    last_next = port_touch ? dig_in : last_reg;
    flag_next = flag_reg;
    if (flag_clr)
      flag_next = 1'b0;
    if (|mismatch)
      flag_next = 1'b1;
  end

  // last-read latch only sees power-on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_reg <= 6'h00;
      flag_reg <= 1'b0;
    end
    else
    begin
      last_reg <= last_next;
      flag_reg <= flag_next;
    end
  end

  // sleep, wake and vector
  always_comb
  begin
    run_next  = run_reg;
    wake_next = 1'b0;
    vec_next  = 1'b0;
    case (run_reg)
      run_awake:
        if (ctl_reg[`CTL_SLEEP])
          run_next = run_asleep;
      run_asleep:
        if (flag_reg)
          run_next = run_waking;
      run_waking:
      begin
        wake_next = 1'b1;
        vec_next  = ctl_reg[`CTL_GIE];
        run_next  = run_awake;
      end
      default: run_next = run_awake;
    endcase
    if (run_reg == run_awake && flag_reg && ctl_reg[`CTL_GIE])
      vec_next = 1'b1;
  end

  // pin drivers
  always_comb
  begin
    pout_next = latch_reg;
    poe_next  = ~dir_rd;
    poe_next[`PIN_INPUT_ONLY] = 1'b0;
    pull_next = wpu_rd & dir_rd & ~ans_pin & {6{~ctl_reg[`CTL_GPU]}};
    pull_next[`PIN_INPUT_ONLY] = master_clear_pin_sel;
    sink_next = ctl_reg[`CTL_WAKE];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg  <= run_awake;
      wake_reg <= 1'b0;
      vec_reg  <= 1'b0;
      pout_reg <= 6'h00;
      poe_reg  <= 6'h00;
      pull_reg <= 6'h00;
      sink_reg <= 1'b0;
    end
    else
    begin
      run_reg  <= run_next;
      wake_reg <= wake_next;
      vec_reg  <= vec_next;
      pout_reg <= pout_next;
      poe_reg  <= poe_next;
      pull_reg <= pull_next;
      sink_reg <= sink_next;
    end
  end

  assign prdata                = rdata_reg;
  assign pready                = ready_reg;
  assign pslverr               = err_reg;
  assign pin_out               = pout_reg;
  assign pin_oe                = poe_reg;
  assign pullup_on             = pull_reg;
  assign wake_sink_on          = sink_reg;
  assign change_interrupt_flag = flag_reg;
  assign wake_request          = wake_reg;
  assign irq_vector_valid      = vec_reg;
  assign irq_vector            = `VECTOR_ADDR;

  a_dir_drive: assert property (@(posedge pclk) disable iff (!presetn)
    $past(soft_rst_n) && !dir_rd[0] |=> pin_oe[0])
    else $error("output pin not driven");
  a_pin3_input: assert property (@(posedge pclk) disable iff (!presetn)
    dir_rd[`PIN_INPUT_ONLY] && !pin_oe[`PIN_INPUT_ONLY])
    else $error("pin three not input");
  a_xtal_dir: assert property (@(posedge pclk) disable iff (!presetn)
    xtal |-> (&dir_rd[5:4]) && (&wpu_rd[5:4]) && (&ioc_rd[5:4]))
    else $error("crystal pins not forced");
  a_analog_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && paddr == `OFS_PIN_VALUE && ans_pin[0] |=> !prdata[0])
    else $error("analog pin read nonzero");
  a_pull_output: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_rd[1] |=> !pullup_on[1])
    else $error("pull-up on output pin");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    |mismatch |=> change_interrupt_flag)
    else $error("mismatch did not set flag");
  a_wake_time: assert property (@(posedge pclk) disable iff (!presetn)
    run_reg == run_asleep && flag_reg |=> ##1 wake_request)
    else $error("no wake two cycles after flag");
  a_sink_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg[`CTL_WAKE] && $stable(ctl_reg) |=> wake_sink_on)
    else $error("sink not on");
  a_pslv_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready)
    else $error("no ready after setup");

  c_port_read:  cover property (@(posedge pclk) port_touch && !pwrite);
  c_flag_set:   cover property (@(posedge pclk) $rose(change_interrupt_flag));
  c_wake:       cover property (@(posedge pclk) wake_request);
  c_vector:     cover property (@(posedge pclk) irq_vector_valid);

endmodule // six_bit_port

// [verification/pin_env.sv]
// pin model: external drivers, pull-ups, floating pins, capacitor on pin zero
// assumes the port samples pin levels on pclk
`timescale 1ns/10ps
module pin_env #(
  parameter int CAP_CYC = 30
)(
  // clock
  input  wire logic       pclk,
  // port side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pullup_on,
  input  wire logic       wake_sink_on,
  output logic      [5:0] pin_in,
  // bench side
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  input  wire logic       cap_en
);
  logic [5:0] lvl_reg = 6'h00;
  logic       cap_reg = 1'b0;
  int         cnt_reg = 0;
  always_ff @(posedge pclk)
  begin
    if (pin_oe[0] && pin_out[0])
    begin
      cap_reg <= 1'b1;
      cnt_reg <= 0;
    end
    else if (wake_sink_on && !pin_oe[0])
    begin
      if (cnt_reg == CAP_CYC)
        cap_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg + 1;
    end
    for (int i = 0; i < 6; i++)
    begin
      if (pin_oe[i])
        lvl_reg[i] <= pin_out[i];
      else if (i == 0 && cap_en)
        lvl_reg[i] <= cap_reg;
      else if (ext_en[i])
        lvl_reg[i] <= ext_val[i];
      else if (pullup_on[i])
        lvl_reg[i] <= 1'b1;
      else
        lvl_reg[i] <= ~lvl_reg[i]; // floating: no stable level
    end
  end
  assign pin_in = lvl_reg;
endmodule // pin_env

// [verification/tb_top.sv]
// bench for the six-bit port: apb tasks and register/pin sequences
// assumes pin_env models the pins and port_cfg.svh gives the map
`timescale 1ns/10ps
`include "port_cfg.svh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, soft_rst_n = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, cap_en = 0, wake_sink_on, change_interrupt_flag, wake_request;
  logic [5:0] pin_in, pin_out, pin_oe, pullup_on, ext_val = 0, ext_en = 6'h3F;
  logic [12:0] irq_vector;
  logic irq_vector_valid;
  int num_errors = 0, checks_done = 0;
  logic [11:0] ofs [6] = '{`OFS_DIRECTION, `OFS_ANALOG_LOW, `OFS_ANALOG_HIGH,
                           `OFS_PULLUP, `OFS_CHANGE_EN, `OFS_CONTROL};
  logic [31:0] rst [6] = '{32'h3F, 32'hFF, 32'h0F, 32'h37, 32'h00, 32'h01};
  initial forever #10 pclk = ~pclk;
  six_bit_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_rst_n(soft_rst_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .wake_sink_on(wake_sink_on),
    .change_interrupt_flag(change_interrupt_flag), .wake_request(wake_request),
    .irq_vector_valid(irq_vector_valid), .irq_vector(irq_vector));
  pin_env env_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .wake_sink_on(wake_sink_on), .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en),
    .cap_en(cap_en));
  task report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task stall(input string what);
    num_errors++;
    $display("[ERR] %0t timeout %s", $time, what);
    report_and_stop();
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        return;
      end
    end
    stall("apb");
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    check(r, x);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task wait_for(input logic wake);
    for (int n = 0; n < 300; n++)
    begin
      @(posedge pclk);
      if ((wake ? wake_request : change_interrupt_flag) === 1'b1)
        return;
    end
    stall("event");
  endtask
  task soft_reset();
    @(posedge pclk);
    soft_rst_n <= 0;
    wt(2);
    soft_rst_n <= 1;
  endtask
  initial
  begin
    wt(20);
    presetn <= 1;
    wt(2);
    check(32'(pin_oe), 0);
    check(32'(pullup_on), 0);
    for (int i = 0; i < 6; i++)
      rd(ofs[i], rst[i]);
    apb(0, 12'h020, 0);
    check({31'h0, e}, 1);
    check(r, 0);
    ext_val <= 6'h08;
    wr(`OFS_ANALOG_LOW, 0);
    wr(`OFS_DIRECTION, 0);
    wr(`OFS_PIN_VALUE, 32'h2A);
    wt(3);
    check(32'(pin_oe), 32'h37);
    check(32'(pin_out), 32'h2A);
    rd(`OFS_PIN_VALUE, 32'h2A);
    rd(`OFS_DIRECTION, 32'h08);
    wr(`OFS_ANALOG_LOW, 32'h0F);
    rd(`OFS_PIN_VALUE, 32'h28);
    check(32'(pin_oe), 32'h37);
    wr(`OFS_DIRECTION, 32'h3F);
    wr(`OFS_ANALOG_LOW, 0);
    ext_en <= 6'h08;
    wr(`OFS_CONTROL, 0);
    wt(3);
    check(32'(pullup_on), 32'h37);
    rd(`OFS_PIN_VALUE, 32'h3F);
    wr(`OFS_DIRECTION, 32'h3E);
    wt(3);
    check(32'(pullup_on), 32'h36);
    wr(`OFS_ANALOG_LOW, 32'h02);
    wt(3);
    check(32'(pullup_on), 32'h34);
    wr(`OFS_CONTROL, 32'h10);
    wt(3);
    check(32'(pullup_on), 32'h3C);
    rd(`OFS_PIN_VALUE, 32'h34);
    for (int m = 1; m < 5; m++)
    begin
      wr(`OFS_CONTROL, 32'(m << 5));
      wr(`OFS_DIRECTION, 0);
      wr(`OFS_PULLUP, 0);
      wr(`OFS_CHANGE_EN, 0);
      rd(`OFS_DIRECTION, (m < 4) ? 32'h38 : 32'h08);
      rd(`OFS_PULLUP, (m < 4) ? 32'h30 : 32'h00);
      rd(`OFS_CHANGE_EN, (m < 4) ? 32'h30 : 32'h00);
    end
    soft_reset();
    rd(`OFS_CONTROL, 32'h01);
    ext_en <= 6'h3F;
    ext_val <= 0;
    wr(`OFS_ANALOG_LOW, 0);
    wr(`OFS_CHANGE_EN, 32'h20);
    rd(`OFS_PIN_VALUE, 0);
    wr(`OFS_STATUS, 1);
    wt(3);
    check({31'h0, change_interrupt_flag}, 0);
    ext_val <= 6'h20;
    wait_for(0);
    wr(`OFS_STATUS, 1);
    wt(2);
    check({31'h0, change_interrupt_flag}, 1);
    rd(`OFS_PIN_VALUE, 32'h20);
    wr(`OFS_STATUS, 1);
    wt(2);
    check({31'h0, change_interrupt_flag}, 0);
    wr(`OFS_ANALOG_LOW, 32'h08);
    wr(`OFS_CHANGE_EN, 32'h10);
    ext_val <= 6'h30;
    wt(5);
    check({31'h0, change_interrupt_flag}, 0);
    wr(`OFS_CHANGE_EN, 32'h20);
    wr(`OFS_ANALOG_LOW, 0);
    rd(`OFS_PIN_VALUE, 32'h30);
    wr(`OFS_STATUS, 1);
    ext_val <= 6'h10;
    wait_for(0);
    soft_reset();
    wt(2);
    check({31'h0, change_interrupt_flag}, 1);
    check({31'h0, irq_vector_valid}, 0);
    wr(`OFS_ANALOG_LOW, 0);
    wr(`OFS_STATUS, 1);
    wt(2);
    check({31'h0, change_interrupt_flag}, 0);
    wr(`OFS_CHANGE_EN, 32'h20);
    wt(2);
    check({31'h0, change_interrupt_flag}, 1);
    wr(`OFS_PIN_VALUE, 1);
    wr(`OFS_DIRECTION, 32'h3E);
    cap_en <= 1;
    wt(5);
    wr(`OFS_DIRECTION, 32'h3F);
    wr(`OFS_CHANGE_EN, 1);
    rd(`OFS_PIN_VALUE, 32'h11);
    wr(`OFS_STATUS, 1);
    wr(`OFS_CONTROL, 32'h0F);
    wt(2);
    check({31'h0, wake_sink_on}, 1);
    wait_for(1);
    check({31'h0, irq_vector_valid}, 1);
    check(32'(irq_vector), 32'h0004);
    report_and_stop();
  end
endmodule // tb_top
